// *** design/dma_chan_pkg.sv ***
// constants, types and register map of the dma channel
package dma_chan_pkg;
    localparam int          DW         = 32;
    localparam logic [31:0] SRC_OFS    = 32'h500602a0;
    localparam logic [31:0] DST_OFS    = 32'h500602a4;
    localparam logic [31:0] LEN_OFS    = 32'h500602a8;
    localparam logic [31:0] CTRL_OFS   = 32'h500602ac;
    localparam logic [31:0] IDX_OFS    = 32'h500602b4;
    localparam logic [31:0] ROUTE_OFS  = 32'h500602b8;
    localparam int          RUN_BIT    = 0;
    localparam int          WID_LSB    = 1;
    localparam int          WID_MSB    = 2;
    localparam int          TRIG_BIT   = 3;
    localparam int          DINC_BIT   = 4;
    localparam int          SINC_BIT   = 5;
    localparam int          CIRC_BIT   = 6;
    localparam int          SENSE_BIT  = 12;
    localparam logic [15:0] CTRL_MASK  = 16'h107f;
    localparam logic [15:0] CTRL_RST   = 16'h0000;
    localparam logic [15:0] IDX_RST    = 16'h0000;
    localparam logic [15:0] LEN_RST    = 16'h0000;
    localparam logic [31:0] ADDR_RST   = 32'h0000_0000;
    localparam logic [3:0]  ROUTE_RST  = 4'hf;
    localparam int          PAIRS      = 9;
    localparam logic [1:0]  W_BYTE     = 2'h0;
    localparam logic [1:0]  W_HALF     = 2'h1;
    localparam logic [1:0]  W_WORD     = 2'h2;
    localparam logic [31:0] STEP_BYTE  = 32'h1;
    localparam logic [31:0] STEP_HALF  = 32'h2;
    localparam logic [31:0] STEP_WORD  = 32'h4;
    localparam logic [31:0] STEP_NONE  = 32'h0;
    localparam logic [15:0] IDX_ONE    = 16'h1;
    localparam logic [1:0]  CNT_FULL   = 2'h2;
    localparam logic [1:0]  CNT_ONE    = 2'h1;

    typedef enum logic [2:0] {S_IDLE, S_ARM, S_RD, S_RDW, S_WR} chan_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic        write;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;
endpackage : dma_chan_pkg

// *** design/dma_channel.sv ***
// one dma channel: control, address stepping, item counter, two-entry buffer
// Function
// - normal mode: stop after programmed length, clear run bit automatically
// - circular mode (trigger mode only): keep running, reset counter, restart
// - source address fixed when its step enable is 0, else advances per item
// - destination address fixed when its step enable is 0, else advances per item
// - trigger select 0 starts at once; 1 waits for peripheral request
// - trusted channel in secure boot forces trigger select to 0
// - width field picks one, two or four byte bus transfers; 11 reserved
// - run bit low means channel idle with clocks gated
// - clearing run mid transfer finishes current item, refuses re-enable until stopped
// - read-only 16-bit counter reports items moved in current transfer
// - counter N means N items done and item N+1 in progress
// - normal mode counter holds final length, clears when next transfer starts
// - circular mode counter clears when the channel restarts
// - sense bit 0 level requests, 1 rising edge requests
// - routing select picks pair; first request to channel 4, second here
//
// Chosen here: the plain strobed port.
module dma_channel (
    input  wire logic                   i_clk,
    input  wire logic                   i_reset_n,
    input  wire logic                   i_ce,
    input  wire dma_chan_pkg::reg_req_t i_reg,
    output logic [31:0]                 o_reg_rdata,
    input  wire logic                   i_trusted,
    input  wire logic [2*dma_chan_pkg::PAIRS-1:0] i_periph_req,
    output logic                        o_ch4_req,
    output logic                        o_chan_clk_en,
    output logic                        o_mem_valid,
    input  wire logic                   i_mem_ready,
    output dma_chan_pkg::mem_req_t      o_mem_req,
    input  wire logic                   i_rsp_valid,
    input  wire logic [31:0]            i_rsp_data,
    output logic                        o_rsp_ready
);
    import dma_chan_pkg::*;

    logic [15:0] ctrl_r;
    logic        run_r;
    logic        abort_r;
    logic [15:0] len_r;
    logic [15:0] idx_r;
    logic [31:0] src_base_r;
    logic [31:0] dst_base_r;
    logic [31:0] src_cur_r;
    logic [31:0] dst_cur_r;
    logic [3:0]  route_r;
    logic        req_prev_r;
    logic        req_pend_r;
    chan_state_t state_r;
    mem_req_t    mem_req_r;
    logic [31:0] buf_r [2];
    logic        wptr_r;
    logic        rptr_r;
    logic [1:0]  cnt_r;

    function automatic logic [31:0] step_of(input logic [1:0] w, input logic en);
        if (!en) begin
            return STEP_NONE;
        end
        unique case (w)
            W_BYTE:  return STEP_BYTE;
            W_HALF:  return STEP_HALF;
            W_WORD:  return STEP_WORD;
            default: return STEP_NONE;
        endcase
    endfunction : step_of

    function automatic logic hit(input logic [31:0] a, input logic [31:0] ofs);
        return a == ofs;
    endfunction : hit

    // effective control fields
    logic       trig_eff;
    logic       circ_eff;
    logic [1:0] width;
    logic [31:0] src_step;
    logic [31:0] dst_step;
    assign trig_eff = ctrl_r[TRIG_BIT] & ~i_trusted;
    assign circ_eff = ctrl_r[CIRC_BIT] & trig_eff;
    assign width    = ctrl_r[WID_MSB:WID_LSB];
    assign src_step = step_of(width, ctrl_r[SINC_BIT]);
    assign dst_step = step_of(width, ctrl_r[DINC_BIT]);

    // request routing: pair index out of range means no peripheral
    logic req_sel;
    logic req_hit;
    logic req_edge;
    always_comb begin
        req_sel   = 1'b0;
        o_ch4_req = 1'b0;
        if (route_r < 4'(PAIRS)) begin
            o_ch4_req = i_periph_req[2*route_r];
            req_sel   = i_periph_req[2*route_r+1];
        end
    end
    assign req_edge = req_sel & ~req_prev_r;
    assign req_hit  = ctrl_r[SENSE_BIT] ? req_pend_r : req_sel;

    // handshakes
    logic wr_ctrl;
    logic start;
    logic done_now;
    logic item_go;
    logic rd_acc;
    logic wr_acc;
    logic buf_push;
    logic buf_pop;
    assign wr_ctrl  = i_reg.wr & hit(i_reg.addr, CTRL_OFS);
    // re-enable is refused while a stop is still pending
    assign start    = wr_ctrl & i_reg.wdata[RUN_BIT] & ~run_r & ~abort_r;
    assign done_now = (state_r == S_ARM) & (idx_r == len_r) & ~abort_r;
    assign item_go  = (state_r == S_ARM) & ~done_now & ~abort_r
                      & (~trig_eff | req_hit) & (cnt_r != CNT_FULL);
    assign o_mem_valid = (state_r == S_RD) | (state_r == S_WR);
    assign o_mem_req   = mem_req_r;
    assign rd_acc   = (state_r == S_RD) & i_mem_ready;
    assign wr_acc   = (state_r == S_WR) & i_mem_ready;
    assign o_rsp_ready = (cnt_r != CNT_FULL);
    assign buf_push = i_rsp_valid & o_rsp_ready;
    assign buf_pop  = wr_acc;
    assign o_chan_clk_en = run_r | (state_r != S_IDLE);

    // control register and run bit
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_r  <= CTRL_RST;
            run_r   <= 1'b0;
            abort_r <= 1'b0;
        end else if (i_ce) begin
            if (wr_ctrl) begin
                ctrl_r <= i_reg.wdata[15:0] & CTRL_MASK;
            end
            if (start) begin
                run_r <= 1'b1;
            end else if (wr_ctrl && !i_reg.wdata[RUN_BIT] && run_r && !(done_now && !circ_eff)) begin
                // no pending stop when the transfer ends anyway: it would never clear in idle
                abort_r <= 1'b1;
            end
            if (done_now && !circ_eff && run_r) begin
                run_r <= 1'b0;
            end
            if (abort_r && state_r == S_ARM) begin
                run_r   <= 1'b0;
                abort_r <= 1'b0;
            end
        end
    end

    // other software registers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            len_r      <= LEN_RST;
            src_base_r <= ADDR_RST;
            dst_base_r <= ADDR_RST;
            route_r    <= ROUTE_RST;
        end else if (i_ce && i_reg.wr) begin
            if (hit(i_reg.addr, LEN_OFS)) begin
                len_r <= i_reg.wdata[15:0];
            end
            if (hit(i_reg.addr, SRC_OFS)) begin
                src_base_r <= i_reg.wdata;
            end
            if (hit(i_reg.addr, DST_OFS)) begin
                dst_base_r <= i_reg.wdata;
            end
            if (hit(i_reg.addr, ROUTE_OFS)) begin
                route_r <= i_reg.wdata[3:0];
            end
        end
    end

    // read data one cycle after the strobe, zero when unmapped
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_reg_rdata <= '0;
        end else if (i_ce) begin
            o_reg_rdata <= '0;
            if (i_reg.rd) begin
                unique case (i_reg.addr)
                    SRC_OFS:   o_reg_rdata <= src_base_r;
                    DST_OFS:   o_reg_rdata <= dst_base_r;
                    LEN_OFS:   o_reg_rdata <= {16'h0, len_r};
                    CTRL_OFS:  o_reg_rdata <= {16'h0, ctrl_r[15:1], run_r};
                    IDX_OFS:   o_reg_rdata <= {16'h0, idx_r};
                    ROUTE_OFS: o_reg_rdata <= {28'h0, route_r};
                    default:   o_reg_rdata <= '0;
                endcase
            end
        end
    end

    // edge request latch; a new edge wins over the consume
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            req_prev_r <= 1'b0;
            req_pend_r <= 1'b0;
        end else if (i_ce) begin
            req_prev_r <= req_sel;
            if (req_edge) begin
                req_pend_r <= 1'b1;
            end else if (item_go || !run_r) begin
                req_pend_r <= 1'b0;
            end
        end
    end

    // item counter and current addresses
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            idx_r     <= IDX_RST;
            src_cur_r <= ADDR_RST;
            dst_cur_r <= ADDR_RST;
        end else if (i_ce) begin
            if (start || (done_now && circ_eff && run_r)) begin
                idx_r     <= IDX_RST;
                src_cur_r <= src_base_r;
                dst_cur_r <= dst_base_r;
            end else if (wr_acc) begin
                idx_r     <= idx_r + IDX_ONE;
                src_cur_r <= src_cur_r + src_step;
                dst_cur_r <= dst_cur_r + dst_step;
            end
        end
    end

    // item sequencer: one read then one write per item
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r   <= S_IDLE;
            mem_req_r <= '0;
        end else if (i_ce) begin
            unique case (state_r)
                S_IDLE: begin
                    if (start) begin
                        state_r <= S_ARM;
                    end
                end
                S_ARM: begin
                    if (abort_r || (done_now && !circ_eff)) begin
                        state_r <= S_IDLE;
                    end else if (item_go) begin
                        state_r         <= S_RD;
                        mem_req_r.write <= 1'b0;
                        mem_req_r.size  <= width;
                        mem_req_r.addr  <= src_cur_r;
                        mem_req_r.wdata <= '0;
                    end
                end
                S_RD: begin
                    if (rd_acc) begin
                        state_r <= S_RDW;
                    end
                end
                S_RDW: begin
                    // the buffer may already hold the word if it came early
                    if (cnt_r != 2'h0) begin
                        state_r         <= S_WR;
                        mem_req_r.write <= 1'b1;
                        mem_req_r.addr  <= dst_cur_r;
                        mem_req_r.wdata <= buf_r[rptr_r];
                    end
                end
                S_WR: begin
                    if (wr_acc) begin
                        state_r <= S_ARM;
                    end
                end
            endcase
        end
    end

    // two-entry buffer between read response and write
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wptr_r <= 1'b0;
            rptr_r <= 1'b0;
            cnt_r  <= 2'h0;
            buf_r  <= '{default: '0};
        end else if (i_ce) begin
            if (buf_push) begin
                buf_r[wptr_r] <= i_rsp_data;
                wptr_r        <= ~wptr_r;
            end
            if (buf_pop) begin
                rptr_r <= ~rptr_r;
            end
            cnt_r <= cnt_r + (buf_push ? CNT_ONE : 2'h0) - (buf_pop ? CNT_ONE : 2'h0);
        end
    end

    // checks
    property p_auto_clear;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && done_now && !circ_eff && run_r && !start) |=> !run_r && state_r == S_IDLE;
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("run bit not cleared at end");

    property p_circ_restart;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && done_now && circ_eff && run_r && !wr_ctrl) |=> run_r && idx_r == IDX_RST;
    endproperty
    a_circ_restart: assert property (p_circ_restart) else $error("circular restart wrong");

    property p_src_fixed;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && wr_acc && !ctrl_r[SINC_BIT] && !start) |=> $stable(src_cur_r);
    endproperty
    a_src_fixed: assert property (p_src_fixed) else $error("source moved");

    property p_dst_step;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && wr_acc && ctrl_r[DINC_BIT] && width == W_WORD && !start)
        |=> dst_cur_r == $past(dst_cur_r) + STEP_WORD;
    endproperty
    a_dst_step: assert property (p_dst_step) else $error("destination step wrong");

    property p_trig_wait;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && state_r == S_ARM && trig_eff && !req_hit && !done_now && !abort_r)
        |=> state_r == S_ARM;
    endproperty
    a_trig_wait: assert property (p_trig_wait) else $error("started without request");

    property p_trusted;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && i_trusted && state_r == S_ARM && !done_now && !abort_r && cnt_r == 2'h0)
        |=> state_r == S_RD;
    endproperty
    a_trusted: assert property (p_trusted) else $error("trusted channel waited");

    property p_stop_pending;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && abort_r && state_r != S_ARM) |=> abort_r && run_r;
    endproperty
    a_stop_pending: assert property (p_stop_pending) else $error("stopped mid item");

    property p_count;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && wr_acc && !start) |=> idx_r == $past(idx_r) + IDX_ONE;
    endproperty
    a_count: assert property (p_count) else $error("counter did not advance");

    property p_hold_final;
        @(posedge i_clk) disable iff (!i_reset_n)
        (state_r == S_IDLE && !start) |=> $stable(idx_r);
    endproperty
    a_hold_final: assert property (p_hold_final) else $error("final count lost");
endmodule : dma_channel

// *** tb/mem_model.sv ***
// memory side partner: answers reads with words derived from the address
module mem_model (
    input  wire logic                   i_clk,
    input  wire logic                   i_reset_n,
    input  wire logic                   i_slow,
    input  wire logic                   i_mem_valid,
    input  wire dma_chan_pkg::mem_req_t i_mem_req,
    output logic                        o_mem_ready,
    output logic                        o_rsp_valid,
    output logic [31:0]                 o_rsp_data,
    input  wire logic                   i_rsp_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    import dma_chan_pkg::*;
    logic        pend_r;
    logic        tick_r;
    logic [2:0]  wait_r;
    logic [31:0] addr_r;
    logic [31:0] last_r;
    // slow mode accepts only every other cycle and answers late
    assign o_mem_ready = !pend_r && (!i_slow || tick_r);
    assign o_rsp_valid = pend_r && (wait_r == 3'h0);
    // idle data bus shows the inverse of the last word, never a stale copy
    assign o_rsp_data  = o_rsp_valid ? (addr_r ^ 32'h5a5ac3c3) : ~last_r;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pend_r <= 1'b0;
            tick_r <= 1'b0;
            wait_r <= 3'h0;
            addr_r <= 32'h0;
            last_r <= 32'h0;
        end else begin
            tick_r <= !tick_r;
            if (i_mem_valid && o_mem_ready && !i_mem_req.write) begin
                pend_r <= 1'b1;
                addr_r <= i_mem_req.addr;
                wait_r <= i_slow ? 3'h6 : 3'h0;
            end else if (wait_r != 3'h0) begin
                wait_r <= wait_r - 3'h1;
            end else if (o_rsp_valid && i_rsp_ready) begin
                pend_r <= 1'b0;
                last_r <= o_rsp_data;
            end
        end
    end
endmodule : mem_model

// *** tb/tb_top.sv ***
// self-checking bench of the dma channel
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dma_chan_pkg::*;
    logic        i_clk, i_reset_n, trusted, slow, rsp_valid, rsp_ready;
    logic        mem_valid, mem_ready, ch4, clk_en;
    logic [17:0] preq;
    logic [31:0] rdata, rsp_data, rnd, csrc, cdst, rv;
    logic [1:0]  cw;
    logic        csi, cdi, wr_seen, snap_w;
    reg_req_t    rq;
    mem_req_t    mq;
    int          n_fail, samples_checked, n_rd, n_wr, snap;

    dma_channel u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(1'b1), .i_reg(rq), .o_reg_rdata(rdata),
        .i_trusted(trusted), .i_periph_req(preq), .o_ch4_req(ch4), .o_chan_clk_en(clk_en),
        .o_mem_valid(mem_valid), .i_mem_ready(mem_ready), .o_mem_req(mq), .i_rsp_valid(rsp_valid),
        .i_rsp_data(rsp_data), .o_rsp_ready(rsp_ready));
    mem_model u_mem (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_slow(slow), .i_mem_valid(mem_valid),
        .i_mem_req(mq), .o_mem_ready(mem_ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
        .i_rsp_ready(rsp_ready));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [31:0] stp(input logic [1:0] w, input logic e);
        return !e ? 32'h0 : (w == 2'h0) ? 32'h1 : (w == 2'h1) ? 32'h2 : 32'h4;
    endfunction : stp

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic give_verdict();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clk);
        rq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        rq.wr <= 1'b0;
    endtask : wr
    // snapshot of accepted writes taken while the read is on the bus
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge i_clk);
        rq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(negedge i_clk);
        snap = n_wr;
        snap_w = wr_seen;
        @(posedge i_clk);
        rq.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic wait_done();
        for (int i = 0; i < 300; i++) begin
            rd(CTRL_OFS, rv);
            if (rv[RUN_BIT] === 1'b0) break;
        end
        chk("run bit", {31'h0, rv[RUN_BIT]}, 32'h0);
    endtask : wait_done
    task automatic go(input logic [15:0] len, input logic [15:0] ctl);
        n_rd = 0;
        n_wr = 0;
        wr(SRC_OFS, csrc);
        wr(DST_OFS, cdst);
        wr(LEN_OFS, {16'h0, len});
        wr(CTRL_OFS, {16'h0, ctl | {10'h0, csi, cdi, 1'b0, cw, 1'b1}});
        #1 chk("clock enable on", {31'h0, clk_en}, 32'h1);
    endtask : go

    // bus monitor: every accepted item against the programmed stepping
    always @(posedge i_clk) begin
        // write taken at this edge: the counter may show the full length for one cycle
        wr_seen = i_reset_n && mem_valid && mem_ready && mq.write;
        if (i_reset_n && mem_valid && mem_ready) begin
            if (!mq.write) begin
                chk("read addr", mq.addr, csrc + 32'(n_rd) * stp(cw, csi));
                n_rd++;
            end else begin
                chk("write addr", mq.addr, cdst + 32'(n_wr) * stp(cw, cdi));
                chk("write data", mq.wdata, (csrc + 32'(n_wr) * stp(cw, csi)) ^ 32'h5a5ac3c3);
                chk("size", {30'h0, mq.size}, {30'h0, cw});
                n_wr++;
            end
        end
    end

    initial begin
        #(20000 * 5);
        n_fail++;
        give_verdict();
    end

    initial begin
        int p;
        logic [15:0] len;
        i_reset_n = 1'b0;
        rq = '0;
        {trusted, slow, preq, csi, cdi, cw, csrc, cdst} = '0;
        rnd = 32'heda0;
        {n_fail, samples_checked, n_rd, n_wr} = '0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd(CTRL_OFS, rv);
        chk("ctrl reset", rv, 32'h0);
        wr(IDX_OFS, 32'h1234);
        rd(IDX_OFS, rv);
        chk("index read only", rv, 32'h0);
        wr(CTRL_OFS, 32'hfffe);
        rd(CTRL_OFS, rv);
        chk("ctrl bits", rv, {16'h0, CTRL_MASK & 16'hfffe});
        rd(32'h50060400, rv);
        chk("unmapped", rv, 32'h0);
        wr(CTRL_OFS, 32'h0);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            csrc = {rnd[31:4], 4'h0};
            rnd = lfsr(rnd);
            cdst = {rnd[31:4], 4'h0};
            {csi, cdi, slow} = rnd[2:0];
            cw = 2'(i % 3);
            len = {14'h0, rnd[4:3]} + 16'h1;
            go(len, 16'h0);
            rd(IDX_OFS, rv);
            chk("index mid", rv, 32'(snap));
            wait_done();
            rd(IDX_OFS, rv);
            chk("index final", rv, {16'h0, len});
            chk("items", 32'(n_wr), {16'h0, len});
            chk("clock enable off", {31'h0, clk_en}, 32'h0);
        end
        // routed request: only the odd bit of the chosen pair may start items
        p = int'(rnd[7:0]) % 9;
        slow <= 1'b0;
        wr(ROUTE_OFS, 32'(p));
        preq <= 18'h3ffff & ~(18'h2 << (2 * p));
        go(16'h2, 16'h0008);
        repeat (10) @(posedge i_clk);
        #1 chk("held without request", 32'(n_wr), 32'h0);
        chk("channel 4 request", {31'h0, ch4}, 32'h1);
        preq[2 * p + 1] <= 1'b1;
        wait_done();
        chk("requested items", 32'(n_wr), 32'h2);
        // edge sense: a held request moves one item only
        preq <= '0;
        go(16'h2, 16'h1008);
        preq[2 * p + 1] <= 1'b1;
        repeat (20) @(posedge i_clk);
        #1 chk("one item per edge", 32'(n_wr), 32'h1);
        preq[2 * p + 1] <= 1'b0;
        @(posedge i_clk);
        preq[2 * p + 1] <= 1'b1;
        wait_done();
        chk("second edge", 32'(n_wr), 32'h2);
        // trusted: trigger and circular are overruled
        trusted <= 1'b1;
        preq <= '0;
        go(16'h1, 16'h0048);
        wait_done();
        chk("trusted start", 32'(n_wr), 32'h1);
        trusted <= 1'b0;
        // circular with fixed addresses, then a stop in mid-item
        {csi, cdi} = 2'b00;
        slow <= 1'b1;
        preq[2 * p + 1] <= 1'b1;
        go(16'h2, 16'h0048);
        for (int i = 0; i < 400; i++) begin
            @(posedge i_clk);
            if (n_wr >= 5) break;
        end
        rd(CTRL_OFS, rv);
        chk("circular run", {31'h0, rv[RUN_BIT]}, 32'h1);
        rd(IDX_OFS, rv);
        chk("circular index", rv, (snap % 2 == 0 && snap_w) ? 32'h2 : 32'(snap % 2));
        for (int i = 0; i < 100; i++) begin
            @(posedge i_clk);
            #1;
            if (mem_valid === 1'b1 && mq.write === 1'b0) break;
        end
        wr(CTRL_OFS, 32'h004c);
        wr(CTRL_OFS, 32'h004d);
        rd(CTRL_OFS, rv);
        chk("stop pending", {31'h0, rv[RUN_BIT]}, 32'h1);
        wait_done();
        chk("item completed", 32'(n_wr), 32'(n_rd));
        repeat (10) @(posedge i_clk);
        #1 chk("stays stopped", {31'h0, mem_valid}, 32'h0);
        give_verdict();
    end
endmodule : tb_top
